// ==== design/uhis_fifo_if.sv ====
// carrier between the status block and its transfer status store
// assumes both ends share pclk
`timescale 1ns/1ps
`default_nettype none
interface uhis_fifo_if;
  logic                          push;
  logic                          pop;
  logic [uhis_pkg::TSTAT_W-1:0]  push_data;
  logic [uhis_pkg::TSTAT_W-1:0]  head;
  logic                          empty;
  logic                          full;
  logic [uhis_pkg::FIFO_CW-1:0]  count;

  modport owner (output push, output pop, output push_data,
                 input head, input empty, input full, input count);
  modport store (input push, input pop, input push_data,
                 output head, output empty, output full, output count);
endinterface
`default_nettype wire

// ==== design/uhis_pad.sv ====
// spare source slot, holds no logic
// assumes nothing of its surroundings
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== design/uhis_pkg.sv ====
// constants, offsets and types for the host-mode interrupt status block
// assumes a 25 MHz pclk and a byte-addressed 32-bit apb register window
package uhis_pkg;

  // clock and line timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_LINE_NS     = 2500;
  localparam int T_IDLE_MS     = 3;
  localparam int LINE_CYC      = (T_LINE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CYC      = (T_IDLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RUN_W         = 17;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_MASK    = 8'h04;
  localparam logic [7:0] OFS_ERR_ST  = 8'h08;
  localparam logic [7:0] OFS_ERR_EN  = 8'h0C;
  localparam logic [7:0] OFS_TSTAT   = 8'h10;
  localparam logic [7:0] OFS_CTRL    = 8'h14;

  // flag positions in the status word and the low-speed bit of ctrl
  localparam int BIT_STALL  = 7;
  localparam int BIT_ATTACH = 6;
  localparam int BIT_RESUME = 5;
  localparam int BIT_IDLE   = 4;
  localparam int BIT_TOKEN  = 3;
  localparam int BIT_FRAME  = 2;
  localparam int BIT_ERROR  = 1;
  localparam int BIT_DETACH = 0;
  localparam int BIT_LOWSPD = 0;

  // widths and reset values
  localparam int FLAG_W   = 8;
  localparam int STATUS_W = 16;
  localparam int TSTAT_W  = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW    = 2;
  localparam int FIFO_CW    = 3;
  localparam logic [FLAG_W-1:0] FLAGS_RST  = 8'h00;
  localparam logic [FLAG_W-1:0] MASK_RST   = 8'h00;
  localparam logic [FLAG_W-1:0] ERR_ST_RST = 8'h00;
  localparam logic [FLAG_W-1:0] ERR_EN_RST = 8'h00;
  localparam logic [FLAG_W-1:0] CTRL_RST   = 8'h00;
  localparam logic [FLAG_W-1:0] W1C_MASK   = 8'hFD;

  // bus line state as {d_plus, d_minus}
  typedef enum logic [1:0] {
    LS_SE0 = 2'b00,
    LS_DM  = 2'b01,
    LS_DP  = 2'b10,
    LS_SE1 = 2'b11
  } uhis_line_t;

endpackage

// ==== design/uhis_top.sv ====
// host-mode interrupt status flags with apb register access
// assumes bus line inputs and event pulses are synchronous to pclk
// Overview of operation
// - the upper eight bits of the status word read zero and ignore writes.
// - a sent stall handshake sets the stall flag, held until software clears it.
// - a non-se0 line with no activity for 2.5 us sets the attach flag.
// - a k-state held 2.5 us sets the resume flag, k depending on the bus speed.
// - an idle line held 3 ms or longer sets the idle flag.
// - a finished token sets the token flag and its status is readable unless the four-entry fifo is already full.
// - a reached frame threshold or a received frame token sets the frame flag.
// - the error flag is read-only and shows only errors whose enable bit is set.
// - a detach sets the detach flag, and it cannot set again until se0 is left.
// - a flag other than the error flag clears only by writing one to it, writing zero leaves it alone.
// - clearing the token flag advances the transfer status fifo.
`timescale 1ns/1ps
`default_nettype none
module uhis_top #(
  parameter int IDLE_CYCLES = uhis_pkg::IDLE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        line_dp,
  input  wire logic        line_dm,
  input  wire logic        stall_sent,
  input  wire logic        token_done,
  input  wire logic [7:0]  token_status,
  input  wire logic        sof_received,
  input  wire logic        sof_threshold,
  input  wire logic [7:0]  error_events,
  output logic             irq
);
  localparam int FW = uhis_pkg::FLAG_W;

  uhis_fifo_if f ();

  logic [FW-1:0]              flags_r;
  logic [FW-1:0]              set_v;
  logic [FW-1:0]              clr_v;
  logic [FW-1:0]              mask_r;
  logic [FW-1:0]              err_st_r;
  logic [FW-1:0]              err_en_r;
  logic [FW-1:0]              ctrl_r;
  logic [FW-1:0]              flag_view;
  logic [uhis_pkg::STATUS_W-1:0] status_word;
  logic [uhis_pkg::RUN_W-1:0] run_cnt_r;
  uhis_pkg::uhis_line_t       line_r;
  uhis_pkg::uhis_line_t       line_now;
  uhis_pkg::uhis_line_t       kstate;
  uhis_pkg::uhis_line_t       jstate;
  logic                       changed;
  logic                       hit_line;
  logic                       hit_idle;
  logic                       detach_armed_r;
  logic                       err_flag;
  logic                       setup;
  logic                       wr_acc;
  logic                       wr_status;
  logic                       tok_pop;
  logic                       mapped;
  logic [31:0]                rd_mux;

  // apb decode
  assign setup     = psel && !penable;
  assign wr_acc    = psel && penable && pwrite;
  assign wr_status = wr_acc && (paddr == uhis_pkg::OFS_STATUS);
  assign pready    = 1'b1;
  assign mapped    = (paddr == uhis_pkg::OFS_STATUS) || (paddr == uhis_pkg::OFS_MASK) ||
                     (paddr == uhis_pkg::OFS_ERR_ST) || (paddr == uhis_pkg::OFS_ERR_EN) ||
                     (paddr == uhis_pkg::OFS_TSTAT)  || (paddr == uhis_pkg::OFS_CTRL);

  // line state tracking
  assign line_now = uhis_pkg::uhis_line_t'({line_dp, line_dm});
  assign kstate   = ctrl_r[uhis_pkg::BIT_LOWSPD] ? uhis_pkg::LS_DP : uhis_pkg::LS_DM;
  assign jstate   = ctrl_r[uhis_pkg::BIT_LOWSPD] ? uhis_pkg::LS_DM : uhis_pkg::LS_DP;
  assign changed  = (line_now != line_r);
  assign hit_line = !changed && (run_cnt_r == uhis_pkg::RUN_W'(uhis_pkg::LINE_CYC - 1));
  assign hit_idle = !changed && (run_cnt_r == uhis_pkg::RUN_W'(IDLE_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_r    <= uhis_pkg::LS_SE0;
      run_cnt_r <= '0;
    end else begin
      line_r <= line_now;
      if (changed) begin
        run_cnt_r <= '0;
      end else if (run_cnt_r != uhis_pkg::RUN_W'(IDLE_CYCLES)) begin
        run_cnt_r <= run_cnt_r + uhis_pkg::RUN_W'(1'b1);
      end
    end
  end

  // detach re-arm once se0 is left
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detach_armed_r <= 1'b1;
    end else if (set_v[uhis_pkg::BIT_DETACH]) begin
      detach_armed_r <= 1'b0;
    end else if (line_r != uhis_pkg::LS_SE0) begin
      detach_armed_r <= 1'b1;
    end
  end

  // hardware set events
  always_comb begin
    set_v = '0;
    set_v[uhis_pkg::BIT_STALL]  = stall_sent;
    set_v[uhis_pkg::BIT_ATTACH] = hit_line && (line_r != uhis_pkg::LS_SE0);
    set_v[uhis_pkg::BIT_RESUME] = hit_line && (line_r == kstate);
    set_v[uhis_pkg::BIT_IDLE]   = hit_idle && (line_r == jstate);
    set_v[uhis_pkg::BIT_TOKEN]  = f.push || (tok_pop && (f.count > 3'h1));
    set_v[uhis_pkg::BIT_FRAME]  = sof_received || sof_threshold;
    set_v[uhis_pkg::BIT_DETACH] = hit_line && (line_r == uhis_pkg::LS_SE0) &&
                                  detach_armed_r;
  end

  // write-one clear on status register writes only, error bit excluded by W1C_MASK
  assign clr_v = wr_status ? (pwdata[FW-1:0] & uhis_pkg::W1C_MASK) : '0;

  // flag storage, set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < FW; gi++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags_r[gi]  <= uhis_pkg::FLAGS_RST[gi];
          err_st_r[gi] <= uhis_pkg::ERR_ST_RST[gi];
        end else begin
          flags_r[gi] <= set_v[gi] | (flags_r[gi] & ~clr_v[gi]);
          if (error_events[gi]) begin
            err_st_r[gi] <= 1'b1;
          end else if (wr_acc && (paddr == uhis_pkg::OFS_ERR_ST) && pwdata[gi]) begin
            err_st_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // read-only error summary
  assign err_flag  = |(err_st_r & err_en_r);
  always_comb begin
    flag_view = flags_r;
    flag_view[uhis_pkg::BIT_ERROR] = err_flag;
  end
  assign status_word = {8'h00, flag_view};

  // transfer status fifo hookup
  assign tok_pop     = wr_status && pwdata[uhis_pkg::BIT_TOKEN] &&
                       flags_r[uhis_pkg::BIT_TOKEN];
  assign f.push      = token_done;
  assign f.push_data = token_status;
  assign f.pop       = tok_pop;

  uhis_tstat_fifo u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (f)
  );

  // software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r   <= uhis_pkg::MASK_RST;
      err_en_r <= uhis_pkg::ERR_EN_RST;
      ctrl_r   <= uhis_pkg::CTRL_RST;
    end else if (wr_acc) begin
      if (paddr == uhis_pkg::OFS_MASK) begin
        mask_r <= pwdata[FW-1:0];
      end
      if (paddr == uhis_pkg::OFS_ERR_EN) begin
        err_en_r <= pwdata[FW-1:0];
      end
      if (paddr == uhis_pkg::OFS_CTRL) begin
        ctrl_r <= pwdata[FW-1:0] & 8'h01;
      end
    end
  end

  // read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      uhis_pkg::OFS_STATUS: rd_mux = {16'h0000, status_word};
      uhis_pkg::OFS_MASK:   rd_mux = {24'h000000, mask_r};
      uhis_pkg::OFS_ERR_ST: rd_mux = {24'h000000, err_st_r};
      uhis_pkg::OFS_ERR_EN: rd_mux = {24'h000000, err_en_r};
      uhis_pkg::OFS_TSTAT:  rd_mux = {24'h000000, f.head};
      uhis_pkg::OFS_CTRL:   rd_mux = {24'h000000, ctrl_r};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !mapped;
    end
  end

  // interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_view & mask_r);
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_status_read;
    setup && !pwrite && (paddr == uhis_pkg::OFS_STATUS);
  endsequence

  sequence s_token_clear;
    tok_pop && !token_done && !f.empty;
  endsequence

  sequence s_stall_kept;
    flags_r[uhis_pkg::BIT_STALL] && !clr_v[uhis_pkg::BIT_STALL];
  endsequence

  property p_upper_zero;
    s_status_read |=> (prdata[31:8] == 24'h000000);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("status upper bits not zero");

  property p_stall_hold;
    stall_sent ##1 s_stall_kept[*2] |=> flags_r[uhis_pkg::BIT_STALL];
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall flag lost");

  property p_attach_time;
    $rose(flags_r[uhis_pkg::BIT_ATTACH]) |->
      ($past(run_cnt_r) == uhis_pkg::RUN_W'(uhis_pkg::LINE_CYC - 1)) &&
      ($past(line_r) != uhis_pkg::LS_SE0);
  endproperty
  a_attach_time: assert property (p_attach_time) else $error("attach set at wrong time");

  property p_resume_k;
    $rose(flags_r[uhis_pkg::BIT_RESUME]) |->
      ($past(line_r) == $past(kstate)) &&
      ($past(run_cnt_r) == uhis_pkg::RUN_W'(uhis_pkg::LINE_CYC - 1));
  endproperty
  a_resume_k: assert property (p_resume_k) else $error("resume set without k-state");

  property p_idle_time;
    $rose(flags_r[uhis_pkg::BIT_IDLE]) |->
      ($past(run_cnt_r) == uhis_pkg::RUN_W'(IDLE_CYCLES - 1)) && ($past(line_r) == $past(jstate));
  endproperty
  a_idle_time: assert property (p_idle_time) else $error("idle set at wrong time");

  property p_token_set;
    (token_done && !f.full) |=> flags_r[uhis_pkg::BIT_TOKEN] && !f.empty;
  endproperty
  a_token_set: assert property (p_token_set) else $error("token flag not set");

  property p_frame_set;
    (sof_received || sof_threshold) |=> flags_r[uhis_pkg::BIT_FRAME];
  endproperty
  a_frame_set: assert property (p_frame_set) else $error("frame flag not set");

  property p_err_enabled;
    (|(error_events & err_en_r)) ##1 (err_en_r == $past(err_en_r)) |->
      status_word[uhis_pkg::BIT_ERROR];
  endproperty
  a_err_enabled: assert property (p_err_enabled) else $error("enabled error not shown");

  property p_detach_armed;
    $rose(flags_r[uhis_pkg::BIT_DETACH]) |->
      $past(detach_armed_r) && ($past(line_r) == uhis_pkg::LS_SE0);
  endproperty
  a_detach_armed: assert property (p_detach_armed) else $error("detach while disarmed");

  property p_zero_write;
    (wr_status && (pwdata[7:0] == 8'h00)) |=> ((flags_r & $past(flags_r)) == $past(flags_r));
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write cleared a flag");

  property p_one_clears;
    (wr_status && pwdata[uhis_pkg::BIT_STALL] && !stall_sent) |=> !flags_r[uhis_pkg::BIT_STALL];
  endproperty
  a_one_clears: assert property (p_one_clears) else $error("stall flag not cleared");

  property p_fifo_advance;
    s_token_clear |=> (f.count == $past(f.count) - 3'h1);
  endproperty
  a_fifo_advance: assert property (p_fifo_advance) else $error("fifo did not advance");

  property p_set_wins;
    (wr_status && pwdata[uhis_pkg::BIT_FRAME] && sof_received) |=> flags_r[uhis_pkg::BIT_FRAME];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

  property p_stall_set;
    stall_sent |=> flags_r[uhis_pkg::BIT_STALL];
  endproperty
  a_stall_set: assert property (p_stall_set) else $error("stall flag not set");

  property p_token_store;
    token_done |=> !f.empty;
  endproperty
  a_token_store: assert property (p_token_store) else $error("token status not stored");

  property p_err_ro;
    (wr_status && status_word[uhis_pkg::BIT_ERROR]) |=> status_word[uhis_pkg::BIT_ERROR];
  endproperty
  a_err_ro: assert property (p_err_ro) else $error("error flag cleared by write");

  property p_detach_hold;
    (!detach_armed_r && (line_r == uhis_pkg::LS_SE0)) |-> !set_v[uhis_pkg::BIT_DETACH];
  endproperty
  a_detach_hold: assert property (p_detach_hold) else $error("detach set again in se0");

  property p_no_stray_clear;
    !wr_status |=> ((flags_r & $past(flags_r)) == $past(flags_r));
  endproperty
  a_no_stray_clear: assert property (p_no_stray_clear) else $error("flag cleared unasked");

  property p_token_pending;
    flags_r[uhis_pkg::BIT_TOKEN] |-> !f.empty;
  endproperty
  a_token_pending: assert property (p_token_pending) else $error("token flag with no status");

  property p_token_refill;
    (tok_pop && (f.count > 3'h1)) |=> flags_r[uhis_pkg::BIT_TOKEN];
  endproperty
  a_token_refill: assert property (p_token_refill) else $error("next token not flagged");

endmodule // uhis_top
`default_nettype wire

// ==== design/uhis_tstat_fifo.sv ====
// transfer status store: small fifo of completed token status bytes
// assumes push is dropped when full unless a pop comes in the same cycle, and pop is ignored when empty
`timescale 1ns/1ps
`default_nettype none
module uhis_tstat_fifo (
  input wire logic     pclk,
  input wire logic     presetn,
  uhis_fifo_if.store   f
);
  logic [uhis_pkg::TSTAT_W-1:0] mem [uhis_pkg::FIFO_DEPTH];
  logic [uhis_pkg::FIFO_AW-1:0] wr_r;
  logic [uhis_pkg::FIFO_AW-1:0] rd_r;
  logic [uhis_pkg::FIFO_CW-1:0] cnt_r;
  logic                         do_push;
  logic                         do_pop;

  assign do_push = f.push && (!f.full || f.pop);
  assign do_pop  = f.pop && !f.empty;
  assign f.empty = (cnt_r == 3'h0);
  assign f.full  = (cnt_r == 3'(uhis_pkg::FIFO_DEPTH));
  assign f.count = cnt_r;
  assign f.head  = mem[rd_r];

  // storage array
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wr_r] <= f.push_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_r  <= 2'h0;
      rd_r  <= 2'h0;
      cnt_r <= 3'h0;
    end else begin
      if (do_push) begin
        wr_r <= wr_r + 2'h1;
      end
      if (do_pop) begin
        rd_r <= rd_r + 2'h1;
      end
      if (do_push && !do_pop) begin
        cnt_r <= cnt_r + 3'h1;
      end else if (do_pop && !do_push) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end
endmodule // uhis_tstat_fifo
`default_nettype wire

// ==== sim/tb_usb_host_irq_status.sv ====
// bench for the interrupt status block, apb tasks and line model
// assumes zero wait state apb and a shortened idle count of 200 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_usb_host_irq_status;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic                 line_dp, line_dm;
  logic [7:0]           paddr, token_status, error_events;
  logic [31:0]          pwdata, prdata;
  logic [3:0]           ev;
  uhis_pkg::uhis_line_t line_req;
  int                   num_errors, n_tests;

  uhis_usb_peer PEER (.pclk(pclk), .presetn(presetn), .line_req(line_req),
                      .line_dp(line_dp), .line_dm(line_dm));
  uhis_top #(.IDLE_CYCLES(200)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_dp(line_dp), .line_dm(line_dm),
    .stall_sent(ev[0]), .token_done(ev[1]), .token_status(token_status),
    .sof_received(ev[2]), .sof_threshold(ev[3]), .error_events(error_events), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, r, exp);
  endtask

  task automatic pulse(input logic [3:0] v, input logic [7:0] e);
    @(posedge pclk);
    ev <= v;
    error_events <= e;
    @(posedge pclk);
    ev <= 4'h0;
    error_events <= 8'h00;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    wt(20000);
    num_errors++;
    summarize();
  end

  initial begin
    logic [31:0] r;
    logic        e;
    num_errors = 0; n_tests = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000; token_status = 8'h00;
    error_events = 8'h00; ev = 4'h0; line_req = uhis_pkg::LS_DP;
    wt(16);
    presetn <= 1'b1;
    rc("mask_rst", uhis_pkg::OFS_MASK, 32'h0000_0000);
    rc("err_en_rst", uhis_pkg::OFS_ERR_EN, 32'h0000_0000);
    rc("ctrl_rst", uhis_pkg::OFS_CTRL, 32'h0000_0000);
    wt(250);
    rc("attach_idle", uhis_pkg::OFS_STATUS, 32'h0000_0050);
    wr(uhis_pkg::OFS_STATUS, 32'hFFFF_FF00);
    rc("zero_write", uhis_pkg::OFS_STATUS, 32'h0000_0050);
    wr(uhis_pkg::OFS_STATUS, 32'h0000_0040);
    rc("one_cleared", uhis_pkg::OFS_STATUS, 32'h0000_0010);
    wr(uhis_pkg::OFS_STATUS, 32'h0000_0010);
    line_req <= uhis_pkg::LS_DM;
    wt(80);
    rc("k_full", uhis_pkg::OFS_STATUS, 32'h0000_0060);
    wr(uhis_pkg::OFS_STATUS, 32'h0000_0060);
    line_req <= uhis_pkg::LS_SE0;
    wt(80);
    rc("detach", uhis_pkg::OFS_STATUS, 32'h0000_0001);
    wr(uhis_pkg::OFS_STATUS, 32'h0000_0001);
    wt(100);
    rc("no_rearm", uhis_pkg::OFS_STATUS, 32'h0000_0000);
    wr(uhis_pkg::OFS_CTRL, 32'h0000_0001);
    line_req <= uhis_pkg::LS_DP;
    wt(80);
    rc("k_low", uhis_pkg::OFS_STATUS, 32'h0000_0060);
    wr(uhis_pkg::OFS_STATUS, 32'h0000_0060);
    fork
      wr(uhis_pkg::OFS_STATUS, 32'h0000_0084);
      begin
        wt(2);
        ev <= 4'h5;
        wt(1);
        ev <= 4'h0;
      end
    join
    rc("set_wins", uhis_pkg::OFS_STATUS, 32'h0000_0084);
    wr(uhis_pkg::OFS_STATUS, 32'h0000_0084);
    rc("stall_clr", uhis_pkg::OFS_STATUS, 32'h0000_0000);
    token_status <= 8'hA5;
    pulse(4'h2, 8'h00);
    token_status <= 8'h3C;
    pulse(4'h2, 8'h00);
    rc("token", uhis_pkg::OFS_STATUS, 32'h0000_0008);
    rc("tstat_a", uhis_pkg::OFS_TSTAT, 32'h0000_00A5);
    wr(uhis_pkg::OFS_STATUS, 32'h0000_0008);
    rc("token_next", uhis_pkg::OFS_STATUS, 32'h0000_0008);
    rc("tstat_b", uhis_pkg::OFS_TSTAT, 32'h0000_003C);
    wr(uhis_pkg::OFS_STATUS, 32'h0000_0008);
    rc("token_clr", uhis_pkg::OFS_STATUS, 32'h0000_0000);
    pulse(4'h0, 8'h01);
    rc("err_off", uhis_pkg::OFS_STATUS, 32'h0000_0000);
    wr(uhis_pkg::OFS_ERR_EN, 32'h0000_0001);
    rc("err_on", uhis_pkg::OFS_STATUS, 32'h0000_0002);
    wr(uhis_pkg::OFS_STATUS, 32'h0000_0002);
    rc("err_ro", uhis_pkg::OFS_STATUS, 32'h0000_0002);
    wr(uhis_pkg::OFS_ERR_ST, 32'h0000_0001);
    rc("err_clr", uhis_pkg::OFS_STATUS, 32'h0000_0000);
    pulse(4'h0, 8'h01);
    rc("err_again", uhis_pkg::OFS_STATUS, 32'h0000_0002);
    wr(uhis_pkg::OFS_ERR_ST, 32'h0000_0001);
    wr(uhis_pkg::OFS_MASK, 32'h0000_0004);
    pulse(4'h8, 8'h00);
    wt(3);
    chk("irq_on", {31'h0, irq}, 32'h0000_0001);
    rc("sof_thr", uhis_pkg::OFS_STATUS, 32'h0000_0004);
    wr(uhis_pkg::OFS_STATUS, 32'h0000_0004);
    wt(2);
    chk("irq_off", {31'h0, irq}, 32'h0000_0000);
    wr(uhis_pkg::OFS_MASK, 32'h0000_0000);
    pulse(4'h4, 8'h00);
    wt(3);
    chk("irq_masked", {31'h0, irq}, 32'h0000_0000);
    rc("sof_rx", uhis_pkg::OFS_STATUS, 32'h0000_0004);
    wr(uhis_pkg::OFS_STATUS, 32'h0000_0004);
    apb(1'b0, 8'hFC, 32'h0000_0000, r, e);
    chk("unmapped_err", {31'h0, e}, 32'h0000_0001);
    chk("unmapped_data", r, 32'h0000_0000);
    chk("pready", {31'h0, pready}, 32'h0000_0001);
    summarize();
  end
endmodule // tb_usb_host_irq_status
`default_nettype wire

// ==== sim/uhis_usb_peer.sv ====
// model of the attached peripheral: drives the bus line state
// assumes the bench asks for a line state, applied on the next pclk edge
`timescale 1ns/1ps
`default_nettype none
module uhis_usb_peer (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire uhis_pkg::uhis_line_t line_req,
  output logic                      line_dp,
  output logic                      line_dm
);
  // line held synchronous to pclk, idle j at full speed out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_dp <= 1'b1;
      line_dm <= 1'b0;
    end else begin
      line_dp <= line_req[1];
      line_dm <= line_req[0];
    end
  end
endmodule // uhis_usb_peer
`default_nettype wire
